// File: rtl/dhp_defines.vh
// constants for the dsp host port multiplexed access sequencer
`ifndef DHP_DEFINES_VH
`define DHP_DEFINES_VH
`define DHP_CNT_W        4
`define DHP_ADDR_W       16
`define DHP_DATA_W       16
`define DHP_T1_RST       4'h2
`define DHP_T2_RST       4'h2
`define DHP_T3_RST       4'h1
`define DHP_T4_RST       4'h3
`define DHP_T5_RST       4'h1
`define DHP_T1_MIN       4'h2
`define DHP_T2_MIN       4'h2
`define DHP_T3_MIN       4'h1
`define DHP_SYNC_STAGES  3
`endif

// File: rtl/dhp_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module dhp_pin_sync (
   core_clk,
   rst,
   pin_in,
   level_q
);
   input  wire core_clk;
   input  wire rst;
   input  wire pin_in;
   output reg  level_q;

   reg s1_q;
   reg s2_q;
   reg s3_q;

   // s1 feeds only s2; the level moves once s2 and s3 agree
   always @(posedge core_clk) begin
      if (rst) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule // dhp_pin_sync

// File: rtl/dhp_seq.v
// sequencer for 16-bit multiplexed accesses to a dsp host port
`timescale 1ns/100ps
`include "dhp_defines.vh"
module dhp_seq #(
   parameter CW = `DHP_CNT_W,
   parameter AW = `DHP_ADDR_W,
   parameter DW = `DHP_DATA_W
) (
   core_clk,
   rst,
   req_valid,
   req_write,
   req_addr,
   req_wdata,
   address_phase_count,
   setup_phase_count,
   strobe_phase_count,
   hold_phase_count,
   recovery_phase_count,
   dsp_wait_line,
   req_ready_q,
   done_q,
   cs_n_q,
   host_data_strobe_n_q,
   ad_out_q,
   ad_oe_q,
   rd_n_q,
   busy_q
);
   input  wire          core_clk;
   input  wire          rst;
   input  wire          req_valid;
   input  wire          req_write;
   input  wire [AW-1:0] req_addr;
   input  wire [DW-1:0] req_wdata;
   input  wire [CW-1:0] address_phase_count;
   input  wire [CW-1:0] setup_phase_count;
   input  wire [CW-1:0] strobe_phase_count;
   input  wire [CW-1:0] hold_phase_count;
   input  wire [CW-1:0] recovery_phase_count;
   input  wire          dsp_wait_line;
   output reg           req_ready_q;
   output reg           done_q;
   output reg           cs_n_q;
   output reg           host_data_strobe_n_q;
   output reg  [DW-1:0] ad_out_q;
   output reg           ad_oe_q;
   output reg           rd_n_q;
   output reg           busy_q;

   // one-hot phase states
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_ADDR = 6'h02;
   localparam [5:0] ST_SETP = 6'h04;
   localparam [5:0] ST_STRB = 6'h08;
   localparam [5:0] ST_HOLD = 6'h10;
   localparam [5:0] ST_RECV = 6'h20;

   reg  [5:0]    state_q;
   reg  [5:0]    state_d;
   reg  [CW-1:0] cnt_q;
   reg  [CW-1:0] cnt_d;
   reg           write_q;
   reg  [DW-1:0] wdata_q;
   reg           wait_seen_q;
   wire          wait_s;

   // clamp a programmed count to its floor so a setting below it cannot break timing
   function [CW-1:0] clamp;
      input [CW-1:0] val;
      input [CW-1:0] floor;
      begin
         clamp = (val < floor) ? floor : val;
      end
   endfunction

   // chip select covers every phase of an access but idle and recovery;
   // the gap it leaves is what the dsp sees as the recovery time
   function sel_on;
      input [5:0] st;
      begin
         sel_on = (st == ST_ADDR) || (st == ST_SETP) ||
                  (st == ST_STRB) || (st == ST_HOLD);
      end
   endfunction

   // the strobe spans setup and strobe phases: it falls one address phase
   // after select, and its width is the setup plus the strobe phase
   function strb_on;
      input [5:0] st;
      begin
         strb_on = (st == ST_SETP) || (st == ST_STRB);
      end
   endfunction

   dhp_pin_sync u_wait_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_in   (dsp_wait_line),
      .level_q  (wait_s)
   );

   // phase sequencing; a phase of count n lasts n+1 bus clocks
   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_IDLE: begin
            if (req_valid) begin
               state_d = ST_ADDR; // chip select and address start together
               cnt_d   = clamp(address_phase_count, `DHP_T1_MIN);
            end
         end
         ST_ADDR: begin
            if (wait_s) begin
               cnt_d = cnt_q; // frozen while the dsp stalls
            end else if (cnt_q != {CW{1'b0}}) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               state_d = ST_SETP;
               cnt_d   = clamp(setup_phase_count, `DHP_T2_MIN);
            end
         end
         ST_SETP: begin
            if (wait_s || wait_seen_q) begin
               cnt_d = cnt_q; // one extra clock after wait drops
            end else if (cnt_q != {CW{1'b0}}) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               state_d = ST_STRB; // strobe stays low, data already on bus
               cnt_d   = clamp(strobe_phase_count, `DHP_T3_MIN);
            end
         end
         ST_STRB: begin
            if (wait_s) begin
               cnt_d = cnt_q;
            end else if (cnt_q != {CW{1'b0}}) begin
               cnt_d = cnt_q - 1'b1; // pulse width from strobe count
            end else begin
               state_d = ST_HOLD; // strobe rises
               cnt_d   = hold_phase_count;
            end
         end
         ST_HOLD: begin
            if (cnt_q != {CW{1'b0}}) begin
               cnt_d = cnt_q - 1'b1; // write data still driven
            end else begin
               state_d = ST_RECV;
               cnt_d   = recovery_phase_count;
            end
         end
         ST_RECV: begin
            if (cnt_q != {CW{1'b0}}) begin
               cnt_d = cnt_q - 1'b1; // idle gap
            end else begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d   = {CW{1'b0}};
         end
      endcase
   end

   // state, capture of the request and registered pins
   always @(posedge core_clk) begin
      if (rst) begin
         state_q              <= ST_IDLE;
         cnt_q                <= {CW{1'b0}};
         write_q              <= 1'b0;
         wdata_q              <= {DW{1'b0}};
         wait_seen_q          <= 1'b0;
         req_ready_q          <= 1'b0;
         done_q               <= 1'b0;
         cs_n_q               <= 1'b1;
         host_data_strobe_n_q <= 1'b1;
         ad_out_q             <= {DW{1'b0}};
         ad_oe_q              <= 1'b0;
         rd_n_q               <= 1'b1;
         busy_q               <= 1'b0;
      end else begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         wait_seen_q <= (state_q == ST_SETP) && wait_s;
         req_ready_q <= (state_d == ST_IDLE) && !(state_q == ST_IDLE && req_valid);
         done_q      <= (state_q == ST_RECV) && (state_d == ST_IDLE);
         busy_q      <= (state_d != ST_IDLE);
         cs_n_q      <= !sel_on(state_d);
         // strobe falls on the step into setup, a full address phase after select
         // so the delay is address count plus one; only counts up to 3 meet it, as 0 and 1 clamp to 2
         host_data_strobe_n_q <= !strb_on(state_d); // width setup plus strobe
         // multiplexed bus: address first, then write data
         if (state_q == ST_IDLE && req_valid) begin
            write_q  <= req_write;
            wdata_q  <= req_wdata;
            rd_n_q   <= req_write;
            ad_out_q <= req_addr[DW-1:0];
            ad_oe_q  <= 1'b1;
         end else if (state_q == ST_ADDR && state_d == ST_SETP) begin
            ad_out_q <= write_q ? wdata_q : {DW{1'b0}};
            ad_oe_q  <= write_q;
         end else if (state_q == ST_HOLD && state_d == ST_RECV) begin
            ad_oe_q  <= 1'b0; // release after hold
            rd_n_q   <= 1'b1;
         end
      end
   end
endmodule // dhp_seq

// File: tb/dhp_seq_chk.sv
// timing checker for the host port access sequencer
`timescale 1ns/100ps
module dhp_seq_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic req_ready_q,
   input wire logic done_q,
   input wire logic cs_n_q,
   input wire logic host_data_strobe_n_q,
   input wire logic ad_oe_q,
   input wire logic busy_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_addr; $fell(cs_n_q) |-> ad_oe_q && busy_q; endproperty
   a_addr: assert property (p_addr) else $error("address not driven with select");
   property p_oe; ad_oe_q |-> !cs_n_q; endproperty
   a_oe: assert property (p_oe) else $error("bus driven outside select");
   property p_lead; $fell(cs_n_q) |-> host_data_strobe_n_q [*3]; endproperty
   a_lead: assert property (p_lead) else $error("strobe too early");
   property p_lead2; $fell(cs_n_q) |-> ##[3:4] $fell(host_data_strobe_n_q); endproperty
   a_lead2: assert property (p_lead2) else $error("strobe too late");
   property p_pulse; $fell(host_data_strobe_n_q) |-> !host_data_strobe_n_q [*4]; endproperty
   a_pulse: assert property (p_pulse) else $error("strobe too short");
   property p_in; !host_data_strobe_n_q |-> !cs_n_q; endproperty
   a_in: assert property (p_in) else $error("strobe outside select");
   property p_gap; $rose(cs_n_q) |-> cs_n_q [*2]; endproperty
   a_gap: assert property (p_gap) else $error("recovery gap too short");
   property p_done; $rose(cs_n_q) |-> ##[1:16] done_q; endproperty
   a_done: assert property (p_done) else $error("no completion");
   property p_one; done_q |=> !done_q; endproperty
   a_one: assert property (p_one) else $error("done too long");
   property p_rdy; req_ready_q |-> cs_n_q && !busy_q; endproperty
   a_rdy: assert property (p_rdy) else $error("ready while busy");
endmodule // dhp_seq_chk

// File: tb/dhp_dsp_model.sv
// dsp host port model: latches the written word, stalls on request
`timescale 1ns/100ps
module dhp_dsp_model (
   input  wire logic        core_clk,
   input  wire logic        cs_n,
   input  wire logic        strobe_n,
   input  wire logic [15:0] ad,
   input  wire logic        stall,
   output logic             wait_q,
   output logic [15:0]      word_q
);
   logic st_q = 1'b1;
   int   n = 0;
   // wait raised at strobe fall for 10 clocks, any point is legal
   always @(posedge core_clk) begin
      st_q <= strobe_n;
      if (st_q && !strobe_n && stall) n <= 10;
      else if (n != 0) n <= n - 1;
      if (!st_q && strobe_n && !cs_n) word_q <= ad;
   end
   assign wait_q = (n != 0);
endmodule // dhp_dsp_model

// File: tb/dhp_seq_tb.sv
// self-checking bench for the host port access sequencer
`timescale 1ns/100ps
module dhp_seq_tb;
   logic clk = 0, rst = 1, vld = 0, wr = 0, stall = 0, wt, rdy, dn, cs, st, oe, rdn, bsy;
   logic [15:0] adr = 16'h0000, wd = 16'h0000, ad, word, a_cf, a_sf;
   // phase counts never go below their floors
   logic [3:0] a = 4'h2, s = 4'h2, t = 4'h1, h = 4'h3, r = 4'h1;
   int xs = 0; // strobe clocks a stall should add: model wait plus one in setup
   logic cs_p = 1, st_p = 1, rd_cf;
   int n_mismatch = 0, checks_done = 0, cyc = 0, t_cf, t_sf, t_sr, t_cr, t_dn, n_dn = 0;
   always #5 clk = ~clk;
   dhp_seq uut (.core_clk(clk), .rst(rst), .req_valid(vld), .req_write(wr), .req_addr(adr),
      .req_wdata(wd), .address_phase_count(a), .setup_phase_count(s), .strobe_phase_count(t),
      .hold_phase_count(h), .recovery_phase_count(r), .dsp_wait_line(wt), .req_ready_q(rdy),
      .done_q(dn), .cs_n_q(cs), .host_data_strobe_n_q(st), .ad_out_q(ad), .ad_oe_q(oe),
      .rd_n_q(rdn), .busy_q(bsy));
   dhp_dsp_model dsp (.core_clk(clk), .cs_n(cs), .strobe_n(st), .ad(ad), .stall(stall),
      .wait_q(wt), .word_q(word));
   // edge times of the bus lines; all seen one clock late, so differences hold
   always @(posedge clk) begin
      cyc <= cyc + 1;
      cs_p <= cs;
      st_p <= st;
      if (cs_p && !cs) begin t_cf <= cyc; a_cf <= ad; rd_cf <= rdn; end
      if (st_p && !st) begin t_sf <= cyc; a_sf <= ad; end
      if (!st_p && st) t_sr <= cyc;
      if (!cs_p && cs) t_cr <= cyc;
      if (dn === 1'b1) begin t_dn <= cyc + 1; n_dn <= n_dn + 1; end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one access: request held until taken, then judged once done
   task automatic acc(input logic w, input logic [15:0] ai, input logic [15:0] di);
      int k;
      int n0;
      k = 0;
      n0 = n_dn;
      while (rdy !== 1'b1 && k < 50) begin @(posedge clk); #1; k++; end
      chk(rdy, 1);
      wr = w; adr = ai; wd = di; vld = 1;
      @(posedge clk);
      #1 vld = 0;
      while (n_dn == n0 && k < 300) begin @(posedge clk); k++; end
      @(posedge clk);
      #1;
      chk(n_dn - n0, 1);
      chk(a_cf, ai);
      chk(t_sf - t_cf, a + 1);
      if (!stall) chk(t_sr - t_sf, s + t + 2);
      else chk(t_sr - t_sf, s + t + 2 + xs);
      chk(t_cr - t_sr, h + 1);
      chk(t_dn - t_cr, r + 2);
      chk(rd_cf, w);
      if (w) chk(a_sf, di);
      if (w) chk(word, di);
   endtask
   task t_walk; acc(1, 16'h1234, 16'habcd); acc(0, 16'h00ff, 16'h0000); endtask
   // longest address phase the strobe delay allows, longest hold and recovery
   task t_long; a = 4'h3; s = 4'h2; t = 4'h1; h = 4'hf; r = 4'hf; acc(1, 16'hffff, 16'h0001); endtask
   // a stall in the strobe phase, then one in the setup phase that adds a clock
   task t_stall;
      t = 4'h7; stall = 1; xs = 10;
      acc(1, 16'h5a5a, 16'ha5a5);
      s = 4'h7; t = 4'h1; xs = 11;
      acc(0, 16'h0a0a, 16'h0000);
      stall = 0;
   endtask
   task final_report;
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1 rst = 0;
      t_walk();
      t_long();
      t_stall();
      final_report();
   end
   // cut a hang short
   initial begin #50000; n_mismatch++; final_report(); end
endmodule // dhp_seq_tb
bind dhp_seq dhp_seq_chk chk (.core_clk(core_clk), .rst(rst), .req_ready_q(req_ready_q),
   .done_q(done_q), .cs_n_q(cs_n_q), .host_data_strobe_n_q(host_data_strobe_n_q),
   .ad_oe_q(ad_oe_q), .busy_q(busy_q));
